// ---- pkg/pwm_stop_pkg.sv ----
`default_nettype none
package pwm_stop_pkg;
	localparam int IN_N = 4;
	localparam int CMP_N = 2;
	localparam int SEL_N = IN_N + CMP_N + 2;
	localparam int IRQ_N = IN_N + 2;
	localparam int SMP_W = 4;
	localparam int ADDR_W = 8;
	localparam int SEL_STRIDE = 4;
	localparam int SEL_CMP0 = IN_N;
	localparam int SEL_OSC = IN_N + CMP_N;
	localparam int SEL_SW = IN_N + CMP_N + 1;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SAMPLE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_SEL0 = 8'h14;
	localparam logic [7:0] ADDR_MASK_SEL = 8'h34;
	localparam logic [7:0] ADDR_HIZ_MODE = 8'h38;
	localparam logic [7:0] ADDR_PIN_STATE = 8'h3C;
	// Control register fields
	localparam int CT_SW = 0;
	localparam int CT_SHA = 1;
	localparam int CT_SHB = 2;
	localparam int CT_OSC = 3;
	localparam int CT_IN_LSB = 4;
	localparam int CT_CMP_LSB = 8;
	localparam int CT_INV_LSB = 10;
	localparam logic [31:0] CTRL_MASK = 32'h0000_3FFF;
	// Status register fields
	localparam int ST_IN_LSB = 0;
	localparam int ST_CMP_LSB = 4;
	localparam int ST_SHA = 6;
	localparam int ST_SHB = 7;
	localparam int ST_OSC = 8;
	// Interrupt status fields
	localparam int IQ_SHA = IN_N;
	localparam int IQ_SHB = IN_N + 1;
	// Reset values and bus response codes
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;
	localparam logic [31:0] SEL_RST = 32'h0000_0000;
	localparam logic [31:0] HIZ_RST = 32'hFFFF_FFFF;
	localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pwm_stop_pkg
`default_nettype wire

// ---- core/pin_event_detect.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_event_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_raw,
	input wire logic invert,
	input wire logic [pwm_stop_pkg::SMP_W-1:0] mode,
	output logic trig,
	output logic high_ok
);
	import pwm_stop_pkg::*;

	logic x;
	logic prev;
	logic [SMP_W-1:0] low_cnt;
	logic [SMP_W-1:0] high_cnt;
	logic next_prev;
	logic next_trig;
	logic next_high_ok;
	logic [SMP_W-1:0] next_low_cnt;
	logic [SMP_W-1:0] next_high_cnt;

	assign x = pin_raw ^ invert;

	always_comb begin
		next_prev = x;
		next_low_cnt = x ? '0 : ((low_cnt >= mode) ? low_cnt : low_cnt + 4'h1);
		next_high_cnt = !x ? '0 : ((high_cnt >= mode) ? high_cnt : high_cnt + 4'h1);
		if (mode == '0) begin
			next_trig = prev && !x;
		end else begin
			next_trig = next_low_cnt >= mode;
		end
		next_high_ok = x && (next_high_cnt >= mode);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev <= 1'b1;
			low_cnt <= '0;
			high_cnt <= '0;
			trig <= 1'b0;
			high_ok <= 1'b0;
		end else begin
			prev <= next_prev;
			low_cnt <= next_low_cnt;
			high_cnt <= next_high_cnt;
			trig <= next_trig;
			high_ok <= next_high_ok;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_EDGE_TRIG: assert property ((mode == '0 && prev && !x) |=> trig)
		else $error("falling edge not detected");
	AST_LEVEL_TRIG: assert property ((mode != '0 && trig) |-> $past(!x))
		else $error("level trigger without asserted input");
endmodule : pin_event_detect
`default_nettype wire

// ---- core/pwm_stop_ctrl.sv ----
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pwm_stop_ctrl #(
	parameter int PINS_A = 16,
	parameter int PINS_B = 16,
	parameter int PAIRS_A = 4,
	parameter int PAIRS_B = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pwm_stop_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [pwm_stop_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [pwm_stop_pkg::IN_N-1:0] disable_request_pin,
	input wire logic [pwm_stop_pkg::CMP_N-1:0] cmp_out,
	input wire logic clock_loss_flag,
	input wire logic [PINS_A+PINS_B-1:0] pwm_pin_level,
	input wire logic [PAIRS_A-1:0] pos_a,
	input wire logic [PAIRS_A-1:0] neg_a,
	input wire logic [PAIRS_B-1:0] pos_b,
	input wire logic [PAIRS_B-1:0] neg_b,
	output logic [PINS_A+PINS_B-1:0] pin_hiz,
	output logic [PINS_A+PINS_B-1:0] pin_gpio,
	output logic irq
);
	import pwm_stop_pkg::*;

	localparam int PIN_N = PINS_A + PINS_B;
	localparam logic [PIN_N-1:0] A_ALL = {{PINS_B{1'b0}}, {PINS_A{1'b1}}};
	localparam logic [PIN_N-1:0] B_ALL = {{PINS_B{1'b1}}, {PINS_A{1'b0}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		return (old & ~m) | (d & m);
	endfunction : merge

	function automatic logic [7:0] sel_addr(input int i);
		return ADDR_SEL0 + 8'(SEL_STRIDE * i);
	endfunction : sel_addr

	function automatic logic addr_hit(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= ADDR_PIN_STATE);
	endfunction : addr_hit

	// Bus state
	logic aw_held, w_held;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic next_aw_held, next_w_held, next_awready, next_wready, next_bvalid;
	logic next_arready, next_rvalid;
	logic [ADDR_W-1:0] next_awaddr_q;
	logic [31:0] next_wdata_q, next_rdata, rd_val;
	logic [3:0] next_wstrb_q;
	logic [1:0] next_bresp, next_rresp;
	logic wr_go;

	// Register state
	logic [31:0] ctrl, sample_sel, next_ctrl, next_sample_sel;
	logic [PIN_N-1:0] sel [SEL_N];
	logic [PIN_N-1:0] next_sel [SEL_N];
	logic [PIN_N-1:0] mask_sel, hiz_mode, next_mask_sel, next_hiz_mode;
	logic [IN_N-1:0] in_flag, high_seen, next_in_flag, next_high_seen;
	logic [CMP_N-1:0] cmp_flag, next_cmp_flag;
	logic sh_a, sh_b, osc_flag, next_sh_a, next_sh_b, next_osc_flag;
	logic [IRQ_N-1:0] irq_status, irq_mask, next_irq_status, next_irq_mask;
	logic [31:0] status, wmask, zw, ow;
	logic cond_masked;

	// Detector outputs
	logic [IN_N-1:0] in_trig, in_high;
	logic [SMP_W-1:0] smp_mode [IN_N];

	// Output state
	logic [PIN_N-1:0] dis, next_pin_hiz, next_pin_gpio;
	logic next_irq;

	genvar g;
	generate
		for (g = 0; g < IN_N; g++) begin : g_in
			assign smp_mode[g] = sample_sel[g*SMP_W +: SMP_W];
			pin_event_detect u_det (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin_raw(disable_request_pin[g]),
				.invert(ctrl[CT_INV_LSB+g]),
				.mode(smp_mode[g]),
				.trig(in_trig[g]),
				.high_ok(in_high[g])
			);
		end
	endgenerate

	assign wr_go = aw_held && w_held && !bvalid;
	assign status = 32'({osc_flag, sh_b, sh_a, cmp_flag, in_flag});
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign zw = wmask & ~wdata_q;
	assign ow = wmask & wdata_q;

	always_comb begin : read_mux
		rd_val = '0;
		case (araddr)
			ADDR_CTRL: rd_val = ctrl;
			ADDR_SAMPLE: rd_val = sample_sel;
			ADDR_STATUS: rd_val = status;
			ADDR_IRQ_STATUS: rd_val = 32'(irq_status);
			ADDR_IRQ_MASK: rd_val = 32'(irq_mask);
			ADDR_MASK_SEL: rd_val = 32'(mask_sel);
			ADDR_HIZ_MODE: rd_val = 32'(hiz_mode);
			ADDR_PIN_STATE: rd_val = 32'(pin_hiz | pin_gpio);
			default: begin
				for (int i = 0; i < SEL_N; i++) begin
					if (araddr == sel_addr(i)) begin
						rd_val = 32'(sel[i]);
					end
				end
			end
		endcase
	end

	always_comb begin : bus_next
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_arready = arready;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_awaddr_q = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_wdata_q = wdata;
			next_wstrb_q = wstrb;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rd_val;
			next_rresp = addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// mask while chosen pins all inactive
	assign cond_masked = (|mask_sel) && !(|(mask_sel & pwm_pin_level));

	always_comb begin : reg_next
		logic we_st;
		we_st = wr_go && (awaddr_q == ADDR_STATUS);
		next_ctrl = ctrl;
		next_sample_sel = sample_sel;
		next_mask_sel = mask_sel;
		next_hiz_mode = hiz_mode;
		next_irq_mask = irq_mask;
		for (int i = 0; i < SEL_N; i++) begin
			next_sel[i] = sel[i];
			if (wr_go && awaddr_q == sel_addr(i)) begin
				next_sel[i] = PIN_N'(merge(32'(sel[i]), wdata_q, wmask));
			end
		end
		if (wr_go) begin
			case (awaddr_q)
				ADDR_CTRL: next_ctrl = merge(ctrl, wdata_q, wmask) & CTRL_MASK;
				ADDR_SAMPLE: next_sample_sel = merge(sample_sel, wdata_q, wmask);
				ADDR_MASK_SEL: next_mask_sel = PIN_N'(merge(32'(mask_sel), wdata_q, wmask));
				ADDR_HIZ_MODE: next_hiz_mode = PIN_N'(merge(32'(hiz_mode), wdata_q, wmask));
				ADDR_IRQ_MASK: next_irq_mask = IRQ_N'(merge(32'(irq_mask), wdata_q, wmask));
				default: ;
			endcase
		end
		// latch pin condition, gated zero write
		for (int i = 0; i < IN_N; i++) begin
			next_in_flag[i] = (in_trig[i] && ctrl[CT_IN_LSB+i] && !cond_masked)
				|| (in_flag[i] && !(we_st && zw[ST_IN_LSB+i]
				&& (smp_mode[i] == '0 || high_seen[i])));
			next_high_seen[i] = (next_in_flag[i] && !in_flag[i]) ? 1'b0
				: (high_seen[i] || in_high[i]);
		end
		for (int j = 0; j < CMP_N; j++) begin
			next_cmp_flag[j] = (cmp_out[j] && ctrl[CT_CMP_LSB+j] && !cond_masked)
				|| (cmp_flag[j] && !(we_st && zw[ST_CMP_LSB+j]));
		end
		// short detect, clear only when pairs inactive
		next_sh_a = (ctrl[CT_SHA] && |(pos_a & neg_a))
			|| (sh_a && !(we_st && zw[ST_SHA] && !(|(pos_a | neg_a))));
		next_sh_b = (ctrl[CT_SHB] && |(pos_b & neg_b))
			|| (sh_b && !(we_st && zw[ST_SHB] && !(|(pos_b | neg_b))));
		// clock loss, clear after clock side flag
		next_osc_flag = (ctrl[CT_OSC] && clock_loss_flag)
			|| (osc_flag && !(we_st && zw[ST_OSC] && !clock_loss_flag));
		// interrupt events, set wins over clear
		next_irq_status = {next_sh_b && !sh_b, next_sh_a && !sh_a, next_in_flag & ~in_flag}
			| (irq_status & ~((wr_go && awaddr_q == ADDR_IRQ_STATUS) ? ow[IRQ_N-1:0] : '0));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
			sample_sel <= SAMPLE_RST;
			mask_sel <= PIN_N'(SEL_RST);
			hiz_mode <= PIN_N'(HIZ_RST);
			irq_mask <= IRQ_MASK_RST;
			irq_status <= '0;
			in_flag <= '0;
			high_seen <= '0;
			cmp_flag <= '0;
			sh_a <= 1'b0;
			sh_b <= 1'b0;
			osc_flag <= 1'b0;
			for (int i = 0; i < SEL_N; i++) begin
				sel[i] <= PIN_N'(SEL_RST);
			end
		end else begin
			ctrl <= next_ctrl;
			sample_sel <= next_sample_sel;
			mask_sel <= next_mask_sel;
			hiz_mode <= next_hiz_mode;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
			in_flag <= next_in_flag;
			high_seen <= next_high_seen;
			cmp_flag <= next_cmp_flag;
			sh_a <= next_sh_a;
			sh_b <= next_sh_b;
			osc_flag <= next_osc_flag;
			for (int i = 0; i < SEL_N; i++) begin
				sel[i] <= next_sel[i];
			end
		end
	end

	always_comb begin : out_next
		dis = '0;
		if (sh_a) dis = dis | A_ALL;
		if (sh_b) dis = dis | B_ALL;
		// selected pins held while flags set
		for (int i = 0; i < IN_N; i++) begin
			if (in_flag[i]) dis = dis | sel[i];
		end
		for (int j = 0; j < CMP_N; j++) begin
			if (cmp_flag[j]) dis = dis | sel[SEL_CMP0+j];
		end
		if (osc_flag) dis = dis | sel[SEL_OSC];
		if (ctrl[CT_SW]) dis = dis | sel[SEL_SW];
		next_pin_hiz = dis & hiz_mode;
		next_pin_gpio = dis & ~hiz_mode;
		next_irq = |(irq_status & irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_hiz <= '0;
			pin_gpio <= '0;
			irq <= 1'b0;
		end else begin
			pin_hiz <= next_pin_hiz;
			pin_gpio <= next_pin_gpio;
			irq <= next_irq;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_PIN_EXCL: assert property ((pin_hiz & pin_gpio) == '0)
		else $error("pin both high impedance and handed over");
	AST_SHORT_SET: assert property ((ctrl[CT_SHA] && |(pos_a & neg_a)) |=> sh_a)
		else $error("short on family A not flagged");
	AST_CLK_SET: assert property ((ctrl[CT_OSC] && clock_loss_flag) |=> osc_flag)
		else $error("clock loss not flagged");
	AST_CMP_SET: assert property ((cmp_out[0] && ctrl[CT_CMP_LSB] && !cond_masked)
		|=> cmp_flag[0])
		else $error("comparator condition not flagged");
	AST_CMP_MASK: assert property ((cond_masked && !cmp_flag[0] && !(wr_go))
		|=> !cmp_flag[0])
		else $error("masked comparator condition flagged");
	AST_SW_STOP: assert property ($rose(ctrl[CT_SW])
		|=> (((pin_hiz | pin_gpio) & $past(sel[SEL_SW])) == $past(sel[SEL_SW])))
		else $error("software request did not stop pins");
	AST_SHORT_PINS: assert property (sh_b |=> &(pin_hiz[PIN_N-1:PINS_A]
		| pin_gpio[PIN_N-1:PINS_A]))
		else $error("short on family B left pins running");
	AST_IN_HOLD: assert property (in_flag[0] ##1 in_flag[0]
		|-> (((pin_hiz | pin_gpio) & $past(sel[0])) == $past(sel[0])))
		else $error("pin condition pins released while flag set");
	AST_SEL_OSC: assert property ((osc_flag && !$past(osc_flag)) ##1 1'b1
		|-> (((pin_hiz | pin_gpio) & $past(sel[SEL_OSC])) == $past(sel[SEL_OSC])))
		else $error("clock loss pins not stopped");
	AST_IRQ: assert property (($rose(in_flag[0]) && irq_mask[0]) |=> irq)
		else $error("pin condition raised no interrupt");
	AST_IN_CLEAR: assert property ($fell(in_flag[0])
		|-> $past(smp_mode[0] == '0 || high_seen[0]))
		else $error("pin flag cleared before high level seen");
	AST_SHORT_CLR: assert property ($fell(sh_a) |-> $past(!(|(pos_a | neg_a))))
		else $error("short flag cleared with pair active");
	AST_OSC_CLR: assert property ($fell(osc_flag) |-> $past(!clock_loss_flag))
		else $error("clock flag cleared while clock loss set");
	AST_BRESP: assert property ($rose(bvalid) |-> $past(aw_held && w_held))
		else $error("write response before address and data");
endmodule : pwm_stop_ctrl
`default_nettype wire

// ---- sim/pwm_timer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwm_timer_model #(
	parameter int PAIRS_A = 4,
	parameter int PAIRS_B = 4,
	parameter int PIN_N = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic short_a,
	input wire logic short_b,
	input wire logic [PIN_N-1:0] pin_off,
	output logic [PIN_N-1:0] pin_level,
	output logic [PAIRS_A-1:0] pos_a,
	output logic [PAIRS_A-1:0] neg_a,
	output logic [PAIRS_B-1:0] pos_b,
	output logic [PAIRS_B-1:0] neg_b
);
	logic phase;
	logic next_phase;

	always_comb begin
		next_phase = run ? ~phase : 1'h0;
	end

	always_ff @(posedge aclk) begin
		phase <= aresetn ? next_phase : 1'h0;
	end

	always_comb begin
		pos_a = run ? {PAIRS_A{phase}} : '0;
		neg_a = run ? {PAIRS_A{~phase}} : '0;
		pos_b = run ? {PAIRS_B{phase}} : '0;
		neg_b = run ? {PAIRS_B{~phase}} : '0;
		// Commanded fault: first pair of a family driven both active
		pos_a[0] = pos_a[0] | short_a;
		neg_a[0] = neg_a[0] | short_a;
		pos_b[0] = pos_b[0] | short_b;
		neg_b[0] = neg_b[0] | short_b;
		pin_level = '0;
		pin_level[PAIRS_A-1:0] = pos_a;
		pin_level[2*PAIRS_A-1:PAIRS_A] = neg_a;
		// A pin taken from the timer reads back inactive
		pin_level = pin_level & ~pin_off;
	end
endmodule : pwm_timer_model
`default_nettype wire

// ---- sim/pwm_stop_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwm_stop_ctrl_tb;
	import pwm_stop_pkg::*;
	logic aclk;
	logic aresetn = 1'h0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [IN_N-1:0] disable_request_pin = 4'hD;
	logic [CMP_N-1:0] cmp_out = '0;
	logic clock_loss_flag = 1'h0;
	logic [31:0] pwm_pin_level, pin_hiz, pin_gpio, pin_off;
	logic [3:0] pos_a, neg_a, pos_b, neg_b;
	logic run = 1'h1;
	logic short_a = 1'h0;
	logic short_b = 1'h0;
	int err_total = 0;
	int compares = 0;

	assign pin_off = pin_hiz | pin_gpio;

	pwm_stop_ctrl u_pwm_stop_ctrl (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .disable_request_pin, .cmp_out, .clock_loss_flag, .pwm_pin_level,
		.pos_a, .neg_a, .pos_b, .neg_b, .pin_hiz, .pin_gpio, .irq
	);

	pwm_timer_model u_pwm_timer_model (
		.aclk, .aresetn, .run, .short_a, .short_b, .pin_off, .pin_level(pwm_pin_level),
		.pos_a, .neg_a, .pos_b, .neg_b
	);

	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic ck_irq(input logic e);
		repeat (2) @(posedge aclk);
		chk({31'h0000_0000, irq}, {31'h0000_0000, e});
	endtask : ck_irq

	// Stop paths settle within three edges for sample mode 0 or 1
	task automatic hz(input logic [31:0] e);
		repeat (4) @(posedge aclk);
		chk(pin_hiz, e);
	endtask : hz

	function automatic logic [7:0] sel(input int i);
		return 8'(ADDR_SEL0 + i * SEL_STRIDE);
	endfunction : sel

	task automatic wc(input logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		chk({30'h0000_0000, bresp}, {30'h0000_0000, r});
	endtask : wc

	task automatic rc(input logic [7:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		chk(rdata, e);
		chk({30'h0000_0000, rresp}, {30'h0000_0000, r});
	endtask : rc

	task automatic t_reset();
		rc(ADDR_CTRL, CTRL_RST);
		rc(ADDR_HIZ_MODE, HIZ_RST);
		rc(ADDR_STATUS, 32'h0000_0000);
		rc(ADDR_PIN_STATE, 32'h0000_0000);
		rc(8'h40, 32'h0000_0000, RESP_SLVERR);
		wc(8'h42, 32'h0000_0001, RESP_SLVERR);
		wstrb <= 4'h2;
		wc(ADDR_SAMPLE, 32'hFFFF_FFFF);
		wstrb <= 4'hF;
		rc(ADDR_SAMPLE, 32'h0000_FF00);
		wc(ADDR_SAMPLE, SAMPLE_RST);
		hz(32'h0000_0000);
	endtask : t_reset

	task automatic t_soft();
		wc(ADDR_HIZ_MODE, 32'h0000_00C0);
		wc(sel(SEL_SW), 32'h0000_00F0);
		wc(ADDR_CTRL, 32'h0000_0001);
		hz(32'h0000_00C0);
		chk(pin_gpio, 32'h0000_0030);
		rc(ADDR_PIN_STATE, 32'h0000_00F0);
		wc(ADDR_CTRL, 32'h0000_0000);
		hz(32'h0000_0000);
		chk(pin_gpio, 32'h0000_0000);
		wc(ADDR_HIZ_MODE, HIZ_RST);
	endtask : t_soft

	task automatic t_input();
		wc(sel(0), 32'h0001_0000);
		wc(sel(1), 32'h0002_0000);
		wc(ADDR_IRQ_MASK, 32'h0000_0003);
		wc(ADDR_CTRL, 32'h0000_0830);
		hz(32'h0000_0000);
		disable_request_pin[0] <= 1'h0;
		hz(32'h0001_0000);
		ck_irq(1'h1);
		disable_request_pin[0] <= 1'h1;
		hz(32'h0001_0000);
		rc(ADDR_IRQ_STATUS, 32'h0000_0001);
		wc(ADDR_IRQ_STATUS, 32'h0000_0001);
		ck_irq(1'h0);
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
		disable_request_pin[1] <= 1'h1;
		hz(32'h0002_0000);
		ck_irq(1'h1);
		wc(ADDR_IRQ_STATUS, 32'h0000_0002);
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
	endtask : t_input

	task automatic t_level();
		wc(ADDR_SAMPLE, 32'h0000_0003);
		wc(ADDR_CTRL, 32'h0000_0010);
		disable_request_pin[0] <= 1'h0;
		repeat (2) @(posedge aclk);
		disable_request_pin[0] <= 1'h1;
		hz(32'h0000_0000);
		disable_request_pin[0] <= 1'h0;
		repeat (4) @(posedge aclk);
		hz(32'h0001_0000);
		wc(ADDR_STATUS, 32'h0000_0000);
		rc(ADDR_STATUS, 32'h0000_0001);
		disable_request_pin[0] <= 1'h1;
		repeat (6) @(posedge aclk);
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
		wc(ADDR_SAMPLE, SAMPLE_RST);
		wc(ADDR_IRQ_STATUS, 32'h0000_003F);
	endtask : t_level

	task automatic t_short(input int f);
		logic [31:0] fam;
		fam = f ? 32'hFFFF_0000 : 32'h0000_FFFF;
		wc(ADDR_CTRL, 32'h0000_0002 << f);
		short_a <= (f == 0);
		short_b <= (f == 1);
		hz(fam);
		ck_irq(1'h0);
		rc(ADDR_IRQ_STATUS, 32'h0000_0010 << f);
		wc(ADDR_IRQ_MASK, 32'h0000_0010 << f);
		ck_irq(1'h1);
		short_a <= 1'h0;
		short_b <= 1'h0;
		wc(ADDR_STATUS, 32'h0000_0000);
		rc(ADDR_STATUS, 32'h0000_0040 << f);
		hz(fam);
		run <= 1'h0;
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
		run <= 1'h1;
		wc(ADDR_IRQ_STATUS, 32'h0000_0030);
		ck_irq(1'h0);
	endtask : t_short

	task automatic t_cmp();
		wc(sel(SEL_CMP0), 32'h0010_0000);
		wc(ADDR_MASK_SEL, 32'h8000_0000);
		wc(ADDR_CTRL, 32'h0000_0100);
		cmp_out[0] <= 1'h1;
		hz(32'h0000_0000);
		wc(ADDR_MASK_SEL, 32'h0000_0003);
		hz(32'h0010_0000);
		cmp_out[0] <= 1'h0;
		hz(32'h0010_0000);
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
		wc(ADDR_MASK_SEL, 32'h0000_0000);
	endtask : t_cmp

	task automatic t_osc();
		wc(sel(SEL_OSC), 32'h0100_0000);
		wc(ADDR_CTRL, 32'h0000_0008);
		clock_loss_flag <= 1'h1;
		hz(32'h0100_0000);
		wc(ADDR_STATUS, 32'h0000_0000);
		rc(ADDR_STATUS, 32'h0000_0100);
		clock_loss_flag <= 1'h0;
		wc(ADDR_STATUS, 32'h0000_0000);
		hz(32'h0000_0000);
	endtask : t_osc

	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_soft();
		t_input();
		t_level();
		t_short(0);
		t_short(1);
		t_cmp();
		t_osc();
		report_and_stop();
	end
endmodule : pwm_stop_ctrl_tb
`default_nettype wire
